// >>> include/otpw_pkg.sv
// package of constants and types for the one-time program array port
// assumes a 100 MHz pclk and an apb master with 32-bit data
package otpw_pkg;
    // array geometry
    localparam int          WORD_W     = 10;
    localparam int          ADDR_W     = 10;
    localparam int          DATA_W     = 8;
    localparam int          WORDS      = 1002;
    localparam logic [9:0]  LAST_ADDR  = 10'h3e9;
    localparam logic [9:0]  TEST_LO    = 10'h3ea;
    localparam logic [9:0]  RESUME_PC  = 10'h000;
    // address advance: last phase of a word, width of the high bits
    localparam logic [1:0]  LAST_PHASE = 2'h3;
    localparam int          HI_W       = WORD_W - DATA_W;
    // reset hold before entry, in microseconds and in cycles
    localparam int          CLK_MHZ    = 100;
    localparam int          HOLD_US    = 10;
    localparam int          HOLD_CYC   = HOLD_US * CLK_MHZ;
    localparam int          HOLD_W     = 11;
    // apb register byte offsets
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_FADDR  = 12'h008;
    localparam logic [11:0] OFS_FDATA  = 12'h00c;
    // field positions
    localparam int          CTRL_ALLOW = 0;
    localparam int          ST_ACTIVE  = 0;
    localparam int          ST_PHASE   = 1;
    localparam int          ST_MODE    = 4;
    localparam int          ST_ADDR    = 16;
    localparam logic        CTRL_RST   = 1'h1;
    // decoded mode of the four select pins
    typedef enum logic [2:0] {
        M_NONE, M_CLEAR, M_WRITE, M_VERIFY, M_INHIBIT
    } otpw_mode_t;
    // pins listed 0..3 as sel[0]..sel[3]
    function automatic otpw_mode_t otpw_decode(input logic [3:0] sel);
        otpw_mode_t m;
        m = M_NONE;
        if (sel == 4'h5)
            m = M_CLEAR;
        else if (sel == 4'he)
            m = M_WRITE;
        else if (sel == 4'hc)
            m = M_VERIFY;
        else if (sel[0] && sel[2] && sel[3])
            m = M_INHIBIT;
        return m;
    endfunction
    // fetch target with the reserved test region folded back to start
    function automatic logic [9:0] otpw_fold(input logic [9:0] a);
        return (a >= TEST_LO) ? RESUME_PC : a;
    endfunction
endpackage

// >>> include/otpw_mem_if.sv
// carrier between the port controller and the program array
// assumes both ends run on pclk
`timescale 1ns/1ps
interface otpw_mem_if;
    logic [9:0] addr;   // word address
    logic       prog;   // program strobe, one cycle
    logic [9:0] wdata;  // bits to program to one
    logic [9:0] rdata;  // registered read data
    modport ctrl (output addr, prog, wdata, input rdata);
    modport mem  (input addr, prog, wdata, output rdata);
endinterface // otpw_mem_if

// >>> core/otpw_array.sv
// one-time program array, 1002 words of 10 bits, registered read
// assumes one clock; a blank cell reads zero, programming only sets bits
`timescale 1ns/1ps
module otpw_array
    import otpw_pkg::*;
(
    // clock and reset
    input wire logic   pclk,
    input wire logic   presetn,
    // array access
    otpw_mem_if.mem    mif
);
    typedef struct packed {
        logic [WORD_W-1:0] rdata_ff; // read data register
    } otpw_arr_st_t;

    otpw_arr_st_t      st_ff;
    otpw_arr_st_t      nxt_st;
    logic [WORD_W-1:0] cells [WORDS];  // the array itself

    // blank part: every cell unprogrammed
    initial begin
        for (int i = 0; i < WORDS; i++) begin
            cells[i] = '0;
        end
    end

    // programming can only turn bits on
    // plain always: the blank-part initial also writes the cells
    always @(posedge pclk) begin
        if (mif.prog && (mif.addr <= LAST_ADDR)) begin
            cells[mif.addr] <= cells[mif.addr] | mif.wdata;
        end
    end

    // read path, out of range reads zero
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdata_ff = (mif.addr <= LAST_ADDR) ? cells[mif.addr] : '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign mif.rdata = st_ff.rdata_ff;

    a_prog_in_range: assert property (
        @(posedge pclk) disable iff (!presetn)
        mif.prog |-> mif.addr <= LAST_ADDR)
        else $error("program strobe outside the array");
endmodule // otpw_array

// >>> core/otpw_entry.sv
// entry into write/verify mode: reset held long enough, then both
// programming supplies seen; pins are synchronous to pclk
`timescale 1ns/1ps
module otpw_entry
    import otpw_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // supply and reset detectors
    input wire logic dev_reset_pin,
    input wire logic vdd_prog_ok,
    input wire logic vpp_prog_ok,
    input wire logic allow,
    // result
    output logic     active_ff
);
    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYC - 1);

    typedef struct packed {
        logic [HOLD_W-1:0] cnt_ff;   // cycles reset has been held
        logic              armed_ff; // hold time reached
        logic              active_ff;
    } otpw_ent_st_t;

    otpw_ent_st_t st_ff;
    otpw_ent_st_t nxt_st;
    logic         supplies;

    assign supplies = vdd_prog_ok && vpp_prog_ok;

    // hold counter, arming and entry
    always_comb begin
        nxt_st = st_ff;
        if (dev_reset_pin) begin
            if (st_ff.cnt_ff == HOLD_LAST)
                nxt_st.armed_ff = 1'b1;
            else
                nxt_st.cnt_ff = st_ff.cnt_ff + 1'b1;
            nxt_st.active_ff = 1'b0;
        end else begin
            nxt_st.cnt_ff = '0;
            // enter only once armed and both supplies up
            if (st_ff.armed_ff && supplies && allow)
                nxt_st.active_ff = 1'b1;
            // losing a supply ends the mode and needs a fresh hold
            if (st_ff.active_ff && !supplies) begin
                nxt_st.active_ff = 1'b0;
                nxt_st.armed_ff  = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign active_ff = st_ff.active_ff;

    a_entry_cause: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(st_ff.active_ff) |->
            $past(st_ff.armed_ff && supplies && !dev_reset_pin))
        else $error("write/verify mode entered without armed supplies");
    c_entry: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(st_ff.active_ff));
endmodule // otpw_entry

// >>> core/otpw_port.sv
// programming port of the one-time program array: mode decode, address
// counter, byte-wide data port, apb registers and a fetch window
// assumes all pins synchronous to pclk and an apb master on pclk
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
// What this block does
// - array holds 1002 ten-bit words
// - fetch in test region resumes at 000H
// - address advances every four clock pulses
// - eight-bit data port, direction by mode
// - entry needs reset hold then supplies
// - select pins decode clear, write, verify, inhibit
// - verify outputs successive words each four pulses
module otpw_port
    import otpw_pkg::*;
(
    // clock and reset
    input wire logic         pclk,
    input wire logic         presetn,
    // apb slave
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [11:0]  paddr,
    input wire logic [31:0]  pwdata,
    output logic [31:0]      prdata_ff,
    output logic             pready_ff,
    output logic             pslverr_ff,
    // entry detectors
    input wire logic         dev_reset_pin,
    input wire logic         vdd_prog_ok,
    input wire logic         vpp_prog_ok,
    output logic             prog_active_ff,
    // programming pins
    input wire logic         prog_clk,
    input wire logic [3:0]   prog_mode_select,
    input wire logic [7:0]   prog_data_in,
    output logic [7:0]       prog_data_out_ff,
    output logic             prog_data_oe_ff
);
    // every check below samples on pclk and rests during reset
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    typedef struct packed {
        logic              allow_ff;    // software permits entry
        logic [ADDR_W-1:0] addr_ff;     // programming word address
        logic [1:0]        phase_ff;    // pulses seen on this word
        logic              clk_prev_ff; // last prog_clk level
        otpw_mode_t        mode_prev_ff;// mode in the previous cycle
        logic              prog_ff;     // program strobe to the array
        logic [WORD_W-1:0] wdata_ff;    // bits to program
        logic [ADDR_W-1:0] fetch_pc_ff; // fetch address after folding
        logic [7:0]        dout_ff;     // data port out
        logic              oe_ff;       // data port drive enable
        logic [31:0]       prdata_ff;
        logic              pready_ff;
        logic              pslverr_ff;
    } otpw_st_t;

    otpw_st_t      st_ff;
    otpw_st_t      nxt_st;
    otpw_mode_t    mode;      // decoded select pins
    logic          active;    // write/verify mode is on
    logic          clk_rise;  // rising edge on prog_clk
    logic          setup;     // apb setup cycle
    logic          access;    // apb access completes at this edge
    logic          hi_slice;  // phase carries the high two bits
    otpw_mem_if    mif ();

    // entry sequencing
    otpw_entry u_entry (
        .pclk          (pclk),
        .presetn       (presetn),
        .dev_reset_pin (dev_reset_pin),
        .vdd_prog_ok   (vdd_prog_ok),
        .vpp_prog_ok   (vpp_prog_ok),
        .allow         (st_ff.allow_ff),
        .active_ff     (active)
    );

    // program array
    otpw_array u_array (
        .pclk    (pclk),
        .presetn (presetn),
        .mif     (mif)
    );

    // decode and edge detect
    assign mode     = otpw_decode(prog_mode_select);
    assign clk_rise = prog_clk && !st_ff.clk_prev_ff;
    assign setup    = psel && !penable;
    assign access   = psel && penable && st_ff.pready_ff;
    assign hi_slice = st_ff.phase_ff[1];

    // array port: programming address in the mode, else the fetch address
    assign mif.addr  = active ? st_ff.addr_ff : st_ff.fetch_pc_ff;
    assign mif.prog  = st_ff.prog_ff;
    assign mif.wdata = st_ff.wdata_ff;

    // next state of the whole port
    always_comb begin
        nxt_st = st_ff;
        nxt_st.clk_prev_ff  = prog_clk;
        nxt_st.mode_prev_ff = mode;
        nxt_st.prog_ff      = 1'b0;
        nxt_st.pready_ff    = 1'b0;
        // programming side, only inside write/verify mode
        if (active) begin
            if (mode == M_CLEAR) begin
                // clear mode zeroes the word address
                nxt_st.addr_ff  = '0;
                nxt_st.phase_ff = '0;
            end else if (clk_rise) begin
                // four pulses make one word step
                nxt_st.phase_ff = st_ff.phase_ff + 1'b1;
                if (st_ff.phase_ff == LAST_PHASE) begin
                    if (st_ff.addr_ff == LAST_ADDR)
                        nxt_st.addr_ff = '0;
                    else
                        nxt_st.addr_ff = st_ff.addr_ff + 1'b1;
                end
            end
            // one program strobe per entry into write mode
            if (mode == M_WRITE && st_ff.mode_prev_ff != M_WRITE) begin
                nxt_st.prog_ff = 1'b1;
                if (hi_slice)
                    nxt_st.wdata_ff = {prog_data_in[HI_W-1:0],
                                       {DATA_W{1'b0}}};
                else
                    nxt_st.wdata_ff = {{HI_W{1'b0}}, prog_data_in};
            end
        end
        // the device drives the port only while verifying
        nxt_st.oe_ff = active && (mode == M_VERIFY);
        if (hi_slice)
            nxt_st.dout_ff = {{(DATA_W-HI_W){1'b0}},
                              mif.rdata[WORD_W-1:DATA_W]};
        else
            nxt_st.dout_ff = mif.rdata[DATA_W-1:0];
        // apb: answer in the cycle after setup
        if (setup) begin
            nxt_st.pready_ff  = 1'b1;
            nxt_st.pslverr_ff = 1'b0;
            nxt_st.prdata_ff  = '0;
            case (paddr)
                OFS_CTRL: begin
                    if (!pwrite)
                        nxt_st.prdata_ff[CTRL_ALLOW] = st_ff.allow_ff;
                end
                OFS_STATUS: begin
                    if (!pwrite) begin
                        nxt_st.prdata_ff[ST_ACTIVE]          = active;
                        nxt_st.prdata_ff[ST_PHASE +: 2]      =
                            st_ff.phase_ff;
                        nxt_st.prdata_ff[ST_MODE +: 3]       = mode;
                        nxt_st.prdata_ff[ST_ADDR +: ADDR_W]  =
                            st_ff.addr_ff;
                    end
                end
                OFS_FADDR: begin
                    if (!pwrite)
                        nxt_st.prdata_ff[ADDR_W-1:0] = st_ff.fetch_pc_ff;
                end
                OFS_FDATA: begin
                    if (!pwrite)
                        nxt_st.prdata_ff[WORD_W-1:0] = mif.rdata;
                end
                default: begin
                    nxt_st.pslverr_ff = 1'b1;  // unmapped offset
                end
            endcase
        end
        // writes land only at the edge that completes the access
        if (access && pwrite) begin
            if (paddr == OFS_CTRL)
                nxt_st.allow_ff = pwdata[CTRL_ALLOW];
            // the test region folds back to the start
            if (paddr == OFS_FADDR)
                nxt_st.fetch_pc_ff = otpw_fold(pwdata[ADDR_W-1:0]);
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff          <= '0;
            st_ff.allow_ff <= CTRL_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from flip-flops
    assign prdata_ff        = st_ff.prdata_ff;
    assign pready_ff        = st_ff.pready_ff;
    assign pslverr_ff       = st_ff.pslverr_ff;
    assign prog_active_ff   = active;
    assign prog_data_out_ff = st_ff.dout_ff;
    assign prog_data_oe_ff  = st_ff.oe_ff;

    // checks, on the default clock and reset above
    a_clear_zeroes: assert property (
        (active && mode == M_CLEAR) |=> st_ff.addr_ff == '0
            && st_ff.phase_ff == '0)
        else $error("clear mode did not zero the address");
    a_word_step: assert property (
        (active && mode != M_CLEAR && clk_rise
            && st_ff.phase_ff == LAST_PHASE && st_ff.addr_ff != LAST_ADDR)
        |=> st_ff.addr_ff == $past(st_ff.addr_ff) + 10'h001)
        else $error("word address did not step after four pulses");
    a_addr_hold: assert property (
        (active && mode != M_CLEAR && !clk_rise) |=> $stable(st_ff.addr_ff)
            && $stable(st_ff.phase_ff))
        else $error("address moved without a pulse");
    a_drive_verify: assert property (
        st_ff.oe_ff |-> $past(active && mode == M_VERIFY))
        else $error("data port driven outside verify");
    a_no_drive_write: assert property (
        (active && mode == M_WRITE) |=> !st_ff.oe_ff)
        else $error("data port driven while writing");
    // a strobe follows the first write cycle only, and lasts one cycle
    a_one_strobe: assert property (
        st_ff.prog_ff |-> ($past(mode) == M_WRITE
            && $past(st_ff.mode_prev_ff) != M_WRITE) ##1 !st_ff.prog_ff)
        else $error("program strobe not single or not from write");
    a_fetch_fold: assert property (
        (access && pwrite && paddr == OFS_FADDR
            && pwdata[ADDR_W-1:0] >= TEST_LO) |=> st_ff.fetch_pc_ff == '0)
        else $error("test region fetch did not resume at start");
    a_ready_pulse: assert property (
        setup |=> st_ff.pready_ff ##1 !st_ff.pready_ff)
        else $error("apb answer not a single cycle");
    c_write: cover property (st_ff.prog_ff);
    c_verify: cover property (st_ff.oe_ff ##1 clk_rise);
    c_fold: cover property (access && pwrite && paddr == OFS_FADDR
        && pwdata[ADDR_W-1:0] >= TEST_LO);
endmodule // otpw_port

// >>> verification/otpw_programmer.sv
// programmer model: select pins, address clock, data port, supplies
// assumes pins sampled on pclk; every task acts from the next pclk edge
`timescale 1ns/1ps
module otpw_programmer #(
    parameter int STAB = 20   // resonator settle time, shortened
) (
    // clock
    input wire logic       pclk,
    // pins toward the device
    output logic           prog_clk,
    output logic [3:0]     prog_mode_select,
    output logic [7:0]     prog_data_in,
    output logic           dev_reset_pin,
    output logic           vdd_prog_ok,
    output logic           vpp_prog_ok,
    // device side of the data port
    input wire logic [7:0] dev_data,
    input wire logic       dev_oe
);
    logic [7:0] drv;   // value we drive
    logic       en;    // we drive the port
    logic [7:0] last;  // last wire level
    // wire level from both enables; released port toggles
    assign prog_data_in = en ? drv : (dev_oe ? dev_data : ~last);
    always @(posedge pclk) last <= prog_data_in;
    // clock pin low and supplies off at power-up
    initial begin
        prog_clk = 1'b0;
        prog_mode_select = 4'h0;
        en = 1'b0;
        drv = 8'h00;
        last = 8'h00;
        dev_reset_pin = 1'b0;
        vdd_prog_ok = 1'b0;
        vpp_prog_ok = 1'b0;
    end
    // hold a mode for n edges
    task automatic step(input logic [3:0] m, input int n);
        @(posedge pclk);
        prog_mode_select <= m;
        repeat (n) @(posedge pclk);
    endtask
    // take or release the data port
    task automatic set_drive(input logic [7:0] d, input logic on);
        @(posedge pclk);
        drv <= d;
        en <= on;
    endtask
    // write pulse of n cycles, then back to inhibit
    task automatic write(input logic [7:0] d, input int n);
        // inhibit first so the device lets go of the port
        step(4'hd, 1);
        set_drive(d, 1'b1);
        step(4'he, n);
        step(4'hd, 0);
        en <= 1'b0;
    endtask
    // n address clock pulses; clock idles low
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge pclk);
            prog_clk <= 1'b1;
            @(posedge pclk);
            prog_clk <= 1'b0;
        end
    endtask
    // reset hold, clear code, settle, supplies, inhibit
    task automatic power_up(input int hold);
        @(posedge pclk);
        dev_reset_pin <= 1'b1;
        repeat (hold) @(posedge pclk);
        dev_reset_pin <= 1'b0;
        prog_mode_select <= 4'h5;
        repeat (STAB) @(posedge pclk);
        vdd_prog_ok <= 1'b1;
        vpp_prog_ok <= 1'b1;
        repeat (2) @(posedge pclk);
        prog_mode_select <= 4'hd;
        @(posedge pclk);
    endtask
    // clear code, then supplies off
    task automatic power_down();
        step(4'h5, 1);
        vdd_prog_ok <= 1'b0;
        vpp_prog_ok <= 1'b0;
        @(posedge pclk);
    endtask
endmodule // otpw_programmer

// >>> verification/test_otp_program_write_verify_port.sv
// self-checking bench of the programming port with a programmer model
// assumes 100 MHz pclk, apb master in the bench, seed fixed
`timescale 1ns/1ps
module test_otp_program_write_verify_port
    import otpw_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite;  // apb side
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata_ff, q;
    logic        pready_ff, pslverr_ff, e;
    logic        dev_reset_pin, vdd_prog_ok, vpp_prog_ok;  // pins
    logic        prog_active_ff, prog_clk, prog_data_oe_ff;
    logic [3:0]  prog_mode_select;
    logic [7:0]  prog_data_in, prog_data_out_ff;
    logic [9:0]  exp_mem [WORDS];  // expected array contents
    logic [9:0]  w, fa;
    int          n_errors = 0;
    int          n_checks = 0;
    logic [3:0]  codes [6] = '{4'he, 4'hc, 4'hd, 4'hf, 4'h7, 4'h5};
    logic [2:0]  mexp  [6] = '{3'h2, 3'h3, 3'h4, 3'h4, 3'h0, 3'h1};
    // device and programmer
    otpw_port uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
        .pslverr_ff(pslverr_ff), .dev_reset_pin(dev_reset_pin),
        .vdd_prog_ok(vdd_prog_ok), .vpp_prog_ok(vpp_prog_ok),
        .prog_active_ff(prog_active_ff), .prog_clk(prog_clk),
        .prog_mode_select(prog_mode_select),
        .prog_data_in(prog_data_in), .prog_data_out_ff(prog_data_out_ff),
        .prog_data_oe_ff(prog_data_oe_ff));
    otpw_programmer prog (.pclk(pclk), .prog_clk(prog_clk),
        .prog_mode_select(prog_mode_select), .prog_data_in(prog_data_in),
        .dev_reset_pin(dev_reset_pin), .vdd_prog_ok(vdd_prog_ok),
        .vpp_prog_ok(vpp_prog_ok), .dev_data(prog_data_out_ff),
        .dev_oe(prog_data_oe_ff));
    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // compare of values
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // compare of single flags
    task automatic chk_flag(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    // port byte of a word at a phase: low byte, then top two bits
    function automatic logic [7:0] port_val(input logic [9:0] v,
                                            input int ph);
        return (ph < 2) ? v[7:0] : {6'h00, v[9:8]};
    endfunction
    // fetch target with the test region folded to zero
    function automatic logic [9:0] fold_exp(input logic [9:0] a);
        return (a > 10'h3e9) ? 10'h000 : a;
    endfunction
    // one apb transfer; waits for pready
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never completes
        do begin
            @(posedge pclk);
        end while (pready_ff !== 1'b1);
        q = prdata_ff;
        e = pslverr_ff;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // program one byte position until it verifies, then overwrite
    task automatic prog_byte(input logic [9:0] a, input int ph,
                             input logic [7:0] d);
        int x;
        x = 0;
        exp_mem[a] = exp_mem[a] | ((ph < 2) ? {2'b00, d} : {d[1:0], 8'h00});
        do begin
            prog.write(d, 4);
            x++;
            prog.step(4'hc, 4);
            @(negedge pclk);
        end while (prog_data_out_ff !== port_val(exp_mem[a], ph) && x < 3);
        chk(prog_data_out_ff, port_val(exp_mem[a], ph));
        chk_flag(prog_data_oe_ff, 1'b1);
        prog.write(d, 4 * x);
        prog.step(4'hd, 2);
        @(negedge pclk);
        chk_flag(prog_data_oe_ff, 1'b0);
    endtask
    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // watchdog well above the expected run length
    initial begin
        repeat (40000) @(posedge pclk);
        n_errors++;
        stop_test();
    end
    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        foreach (exp_mem[i]) exp_mem[i] = 10'h000;
        void'($urandom(50659));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk_flag(prog_data_oe_ff, 1'b0);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(q, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk_flag(e, 1'b1);
        // short reset hold must not enter
        prog.power_up(HOLD_CYC / 2);
        @(negedge pclk);
        chk_flag(prog_active_ff, 1'b0);
        prog.power_down();
        prog.power_up(HOLD_CYC + 2);
        @(negedge pclk);
        chk_flag(prog_active_ff, 1'b1);
        // five pulses: address 1, phase 1
        prog.pulse(5);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk({q[25:16], q[2:1]}, 12'h005);
        // six select codes, clear last
        foreach (codes[i]) begin
            prog.set_drive(8'h00, codes[i] == 4'he);
            prog.step(codes[i], 2);
            apb(1'b0, OFS_STATUS, 32'h0);
            chk(q[6:4], mexp[i]);
        end
        prog.set_drive(8'h00, 1'b0);
        chk(q[25:16], 10'h000);
        // six words below the test region
        prog.step(4'hd, 1);
        for (int i = 0; i < 6; i++) begin
            w = (i == 2) ? 10'h3ff : 10'($urandom());
            prog_byte(10'(i), 0, w[7:0]);
            prog.pulse(2);
            prog_byte(10'(i), 2, {6'h00, w[9:8]});
            prog.pulse(2);
            apb(1'b0, OFS_STATUS, 32'h0);
            chk(q[25:16], i + 1);
        end
        // read back every phase of the six words
        prog.step(4'h5, 2);
        prog.step(4'hd, 1);
        prog.step(4'hc, 1);
        for (int i = 0; i < 24; i++) begin
            repeat (4) @(posedge pclk);
            @(negedge pclk);
            chk(prog_data_out_ff, port_val(exp_mem[i / 4], i % 4));
            prog.pulse(1);
        end
        prog.step(4'hd, 1);
        prog.step(4'h5, 1);
        // a full sweep wraps back to address zero
        prog.step(4'hd, 1);
        prog.pulse(4 * WORDS);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk({q[25:16], q[2:1]}, 12'h000);
        // fetch window after leaving the mode
        prog.power_down();
        for (int i = 0; i < 5; i++) begin
            fa = (i == 0) ? 10'($urandom_range(5)) :
                 (i == 1) ? 10'h3e9 : (i == 2) ? 10'h3ea :
                 (i == 3) ? 10'h3ff : 10'h3ea + 10'($urandom_range(21));
            apb(1'b1, OFS_FADDR, {22'h0, fa});
            apb(1'b0, OFS_FADDR, 32'h0);
            chk(q[9:0], fold_exp(fa));
            apb(1'b0, OFS_FDATA, 32'h0);
            chk(q[9:0], exp_mem[fold_exp(fa)]);
        end
        // entry blocked while not allowed
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(q, 32'h0);
        prog.power_up(HOLD_CYC + 2);
        @(negedge pclk);
        chk_flag(prog_active_ff, 1'b0);
        stop_test();
    end
endmodule // test_otp_program_write_verify_port
